// *** hw/cfs_pkg.sv ***
package cfs_pkg;
  // Configuration register indices
  localparam logic [7:0] CFS_IDX_LDN = 8'h07;
  localparam logic [7:0] CFS_IDX_CFG_LO = 8'h26;
  localparam logic [7:0] CFS_IDX_CFG_HI = 8'h27;
  localparam logic [7:0] CFS_IDX_RSVD28 = 8'h28;
  localparam logic [7:0] CFS_IDX_TEST_SPLIT = 8'h29;
  localparam logic [7:0] CFS_IDX_LDEV_FIRST = 8'h30;
  localparam logic [7:0] CFS_IDX_ACT = 8'h30;
  localparam logic [7:0] CFS_IDX_BASE1_HI = 8'h60;
  localparam logic [7:0] CFS_IDX_BASE1_LO = 8'h61;
  localparam logic [7:0] CFS_IDX_BASE2_HI = 8'h62;
  localparam logic [7:0] CFS_IDX_BASE2_LO = 8'h63;
  // Plain read/write test registers
  localparam int CFS_NUM_TEST = 8;
  localparam logic [7:0] CFS_TEST_IDX [CFS_NUM_TEST] = '{
    8'h19, 8'h25, 8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h2F};
  localparam logic [7:0] CFS_SPLIT_STBY_MASK = 8'h81;
  localparam logic [7:0] CFS_SPLIT_TEST_MASK = 8'h7E;
  // Reset values, data port offset and activation bit position
  localparam logic [7:0] CFS_ZERO8 = 8'h00;
  localparam logic [15:0] CFS_ZERO16 = 16'h0000;
  localparam logic [7:0] CFS_ONES8 = 8'hFF;
  localparam logic [15:0] CFS_CFG_DEF_A = 16'h002E;
  localparam logic [15:0] CFS_CFG_DEF_B = 16'h004E;
  localparam logic [15:0] CFS_DATA_PORT_OFS = 16'h0001;
  localparam int CFS_ACT_BIT = 0;
  // Logical device banks and permitted base window
  localparam int CFS_NUM_LDEV = 8;
  localparam logic [15:0] CFS_BASE_MIN = 16'h0100;
  localparam logic [15:0] CFS_BASE_MAX = 16'h0FF8;
  localparam logic [15:0] CFS_BASE_ALIGN = 16'h0007;
  localparam logic [15:0] CFS_BASE_SPAN = 16'h0007;
  localparam logic [7:0] CFS_TWO_BASE_DEF = 8'h10;
  // Host command register offsets
  localparam logic [3:0] CFS_H_ADDR = 4'h0;
  localparam logic [3:0] CFS_H_WRITE = 4'h1;
  localparam logic [3:0] CFS_H_READ = 4'h2;
  localparam logic [3:0] CFS_H_STATUS = 4'h3;
  localparam logic [3:0] CFS_H_RDATA = 4'h4;
  localparam logic [3:0] CFS_H_RELOC = 4'h5;
  localparam logic [3:0] CFS_H_CFGBASE = 4'h6;
  localparam int CFS_ST_BUSY = 0;
  localparam int CFS_ST_NORESP = 1;
  localparam int CFS_ST_REFUSED = 2;
  localparam logic [1:0] CFS_RELOC_LAST = 2'h3;

  typedef enum logic [1:0] {
    CFS_HS_IDLE,
    CFS_HS_RWAIT,
    CFS_HS_RELOC
  } cfs_hstate_t;
endpackage

// *** hw/cfs_link_if.sv ***
interface cfs_link_if;
  logic [15:0] io_addr;
  logic [7:0] io_wdata;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_rdata;
  logic io_rvalid;

  modport dev (
    input io_addr, io_wdata, io_wr, io_rd,
    output io_rdata, io_rvalid
  );
  modport host (
    output io_addr, io_wdata, io_wr, io_rd,
    input io_rdata, io_rvalid
  );
endinterface

// *** hw/cfs_ldev_bank.sv ***
module cfs_ldev_bank
  import cfs_pkg::*;
#(
  parameter bit TWO_BASES = 1'b0
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  input wire logic wr_i,
  input wire logic [7:0] idx_i,
  input wire logic [7:0] wdata_i,
  input wire logic pwr_set_i,
  input wire logic pwr_clr_i,
  output logic active_o,
  output logic [15:0] base1_o,
  output logic [15:0] base2_o,
  output logic [7:0] rdata_o
);
  logic act_r, act_nxt;
  logic [15:0] base1_r, base1_nxt;
  logic [15:0] base2_r, base2_nxt;

  // Next state of this bank's activation and base registers
  always_comb begin
    act_nxt = act_r;
    base1_nxt = base1_r;
    base2_nxt = base2_r;
    if (clr_i) begin
      act_nxt = 1'b0;
      base1_nxt = CFS_ZERO16;
      base2_nxt = CFS_ZERO16;
    end else begin
      if (wr_i) begin
        if (idx_i == CFS_IDX_ACT) begin
          act_nxt = wdata_i[CFS_ACT_BIT];
        end else if (idx_i == CFS_IDX_BASE1_HI) begin
          base1_nxt[15:8] = wdata_i;
        end else if (idx_i == CFS_IDX_BASE1_LO) begin
          base1_nxt[7:0] = wdata_i;
        end else if (TWO_BASES && idx_i == CFS_IDX_BASE2_HI) begin
          base2_nxt[15:8] = wdata_i;
        end else if (TWO_BASES && idx_i == CFS_IDX_BASE2_LO) begin
          base2_nxt[7:0] = wdata_i;
        end
      end
      // One shared bit: power control and activation mirror each other
      if (pwr_set_i) begin
        act_nxt = 1'b1;
      end else if (pwr_clr_i) begin
        act_nxt = 1'b0;
      end
    end
  end

  // Bank registers
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      act_r <= 1'b0;
      base1_r <= CFS_ZERO16;
      base2_r <= CFS_ZERO16;
    end else begin
      act_r <= act_nxt;
      base1_r <= base1_nxt;
      base2_r <= base2_nxt;
    end
  end

  // Read view; reserved and unused indices read zero
  always_comb begin
    rdata_o = CFS_ZERO8;
    if (idx_i == CFS_IDX_ACT) begin
      rdata_o[CFS_ACT_BIT] = act_r;
    end else if (idx_i == CFS_IDX_BASE1_HI) begin
      rdata_o = base1_r[15:8];
    end else if (idx_i == CFS_IDX_BASE1_LO) begin
      rdata_o = base1_r[7:0];
    end else if (TWO_BASES && idx_i == CFS_IDX_BASE2_HI) begin
      rdata_o = base2_r[15:8];
    end else if (TWO_BASES && idx_i == CFS_IDX_BASE2_LO) begin
      rdata_o = base2_r[7:0];
    end
  end

  assign active_o = act_r;
  assign base1_o = base1_r;
  assign base2_o = base2_r;
endmodule

// *** hw/cfs_cfg_device.sv ***
// The address-and-strobe port is this design's own decision.
module cfs_cfg_device
  import cfs_pkg::*;
#(
  parameter logic [7:0] TWO_BASE_MASK = CFS_TWO_BASE_DEF
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  cfs_link_if.dev link,
  input wire logic strap_sel_i,
  input wire logic cfg_state_i,
  input wire logic standby_por_i,
  input wire logic pci_reset_i,
  input wire logic soft_reset_i,
  input wire logic test_power_on_clear_i,
  input wire logic [7:0] pwr_set_i,
  input wire logic [7:0] pwr_clr_i,
  output logic [7:0] unit_active_o,
  output logic [7:0] dev_hit_o,
  output logic [15:0] cfg_base_o
);
  // Base must sit inside the window and on an eight byte boundary
  function automatic logic base_ok(input logic [15:0] b);
    base_ok = (b >= CFS_BASE_MIN) && (b <= CFS_BASE_MAX) && ((b & CFS_BASE_ALIGN) == CFS_ZERO16);
  endfunction

  // Address falls inside the register span of a base
  function automatic logic in_span(input logic [15:0] a, input logic [15:0] b);
    in_span = (a >= b) && (a <= b + CFS_BASE_SPAN);
  endfunction

  logic [7:0] index_r, index_nxt;
  logic [7:0] ldn_r, ldn_nxt;
  logic [15:0] cfg_addr_r, cfg_addr_nxt;
  logic [7:0] cfg_lo_pend_r, cfg_lo_pend_nxt;
  logic strap_load_r, strap_load_nxt;
  logic [7:0] test_r [CFS_NUM_TEST];
  logic [7:0] test_nxt [CFS_NUM_TEST];
  logic [7:0] split_r, split_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [7:0] hit_r, hit_nxt;
  logic idx_sel, dat_sel, dat_wr, bank_clr;
  logic [7:0] glob_rdata;
  logic [7:0] bank_act;
  logic [15:0] bank_base1 [CFS_NUM_LDEV];
  logic [15:0] bank_base2 [CFS_NUM_LDEV];
  logic [7:0] bank_rdata [CFS_NUM_LDEV];

  // Port decode, live only in the configuration state
  always_comb begin
    idx_sel = cfg_state_i && (link.io_addr == cfg_addr_r);
    dat_sel = cfg_state_i && (link.io_addr == (cfg_addr_r + CFS_DATA_PORT_OFS));
    dat_wr = dat_sel && link.io_wr;
    bank_clr = standby_por_i || pci_reset_i || soft_reset_i;
  end

  // Eight independent banks; only the selected one sees data writes
  for (genvar g = 0; g < CFS_NUM_LDEV; g++) begin : g_bank
    cfs_ldev_bank #(
      .TWO_BASES(TWO_BASE_MASK[g])
    ) u_bank (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .clr_i(bank_clr),
      .wr_i(dat_wr && (ldn_r == 8'(g)) && (index_r >= CFS_IDX_LDEV_FIRST)),
      .idx_i(index_r),
      .wdata_i(link.io_wdata),
      .pwr_set_i(pwr_set_i[g]),
      .pwr_clr_i(pwr_clr_i[g]),
      .active_o(bank_act[g]),
      .base1_o(bank_base1[g]),
      .base2_o(bank_base2[g]),
      .rdata_o(bank_rdata[g])
    );
  end

  // Global register read view
  always_comb begin
    glob_rdata = CFS_ZERO8;
    if (index_r == CFS_IDX_LDN) begin
      glob_rdata = ldn_r;
    end else if (index_r == CFS_IDX_CFG_LO) begin
      glob_rdata = cfg_addr_r[7:0];
    end else if (index_r == CFS_IDX_CFG_HI) begin
      glob_rdata = cfg_addr_r[15:8];
    end else if (index_r == CFS_IDX_TEST_SPLIT) begin
      glob_rdata = split_r;
    end
    for (int k = 0; k < CFS_NUM_TEST; k++) begin
      if (index_r == CFS_TEST_IDX[k]) begin
        glob_rdata = test_r[k];
      end
    end
  end

  // Index, bank select and configuration port address
  always_comb begin
    index_nxt = index_r;
    ldn_nxt = ldn_r;
    cfg_addr_nxt = cfg_addr_r;
    cfg_lo_pend_nxt = cfg_lo_pend_r;
    strap_load_nxt = 1'b0;
    if (idx_sel && link.io_wr) begin
      index_nxt = link.io_wdata;
    end
    if (dat_wr && index_r == CFS_IDX_LDN) begin
      ldn_nxt = link.io_wdata;
    end
    if (dat_wr && index_r == CFS_IDX_CFG_LO) begin
      cfg_lo_pend_nxt = link.io_wdata;
    end
    if (dat_wr && index_r == CFS_IDX_CFG_HI) begin
      cfg_addr_nxt = {link.io_wdata, cfg_lo_pend_r[7:1], 1'b0};
    end
    if (bank_clr) begin
      ldn_nxt = CFS_ZERO8;
    end
    // Soft and standby resets leave the port where it is
    if (strap_load_r || pci_reset_i) begin
      cfg_addr_nxt = strap_sel_i ? CFS_CFG_DEF_B : CFS_CFG_DEF_A;
      cfg_lo_pend_nxt = CFS_ZERO8;
    end
  end

  // Test registers; writes land, power-on events clear
  always_comb begin
    for (int k = 0; k < CFS_NUM_TEST; k++) begin
      test_nxt[k] = test_r[k];
      if (dat_wr && index_r == CFS_TEST_IDX[k]) begin
        test_nxt[k] = link.io_wdata;
      end
      if (standby_por_i) begin
        test_nxt[k] = CFS_ZERO8;
      end
    end
    split_nxt = split_r;
    if (dat_wr && index_r == CFS_IDX_TEST_SPLIT) begin
      split_nxt = link.io_wdata;
    end
    if (standby_por_i) begin
      split_nxt = split_nxt & ~CFS_SPLIT_STBY_MASK;
    end
    if (test_power_on_clear_i) begin
      split_nxt = split_nxt & ~CFS_SPLIT_TEST_MASK;
    end
  end

  // Read answer one cycle after the strobe, and device window hits
  always_comb begin
    rdata_nxt = rdata_r;
    rvalid_nxt = 1'b0;
    if (link.io_rd && idx_sel) begin
      rdata_nxt = index_r;
      rvalid_nxt = 1'b1;
    end else if (link.io_rd && dat_sel) begin
      rdata_nxt = (index_r >= CFS_IDX_LDEV_FIRST) ? bank_rdata[ldn_r[2:0]] : glob_rdata;
      rvalid_nxt = 1'b1;
    end
    for (int d = 0; d < CFS_NUM_LDEV; d++) begin
      hit_nxt[d] = (link.io_rd || link.io_wr) && bank_act[d] && (
        (base_ok(bank_base1[d]) && in_span(link.io_addr, bank_base1[d])) ||
        (TWO_BASE_MASK[d] && base_ok(bank_base2[d]) && in_span(link.io_addr, bank_base2[d])));
    end
  end

  // Register stage for all device state outside the banks
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      index_r <= CFS_ZERO8;
      ldn_r <= CFS_ZERO8;
      cfg_addr_r <= CFS_CFG_DEF_A;
      cfg_lo_pend_r <= CFS_ZERO8;
      strap_load_r <= 1'b1;
      for (int k = 0; k < CFS_NUM_TEST; k++) begin
        test_r[k] <= CFS_ZERO8;
      end
      split_r <= CFS_ZERO8;
      rdata_r <= CFS_ZERO8;
      rvalid_r <= 1'b0;
      hit_r <= CFS_ZERO8;
      unit_active_o <= CFS_ZERO8;
      cfg_base_o <= CFS_CFG_DEF_A;
    end else begin
      index_r <= index_nxt;
      ldn_r <= ldn_nxt;
      cfg_addr_r <= cfg_addr_nxt;
      cfg_lo_pend_r <= cfg_lo_pend_nxt;
      strap_load_r <= strap_load_nxt;
      test_r <= test_nxt;
      split_r <= split_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      hit_r <= hit_nxt;
      unit_active_o <= bank_act;
      cfg_base_o <= cfg_addr_nxt;
    end
  end

  assign dev_hit_o = hit_r;
  assign link.io_rdata = rdata_r;
  assign link.io_rvalid = rvalid_r;
endmodule

// *** hw/cfs_cfg_host.sv ***
module cfs_cfg_host
  import cfs_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  cfs_link_if.host link,
  input wire logic [3:0] sw_addr_i,
  input wire logic [15:0] sw_wdata_i,
  input wire logic sw_wr_i,
  input wire logic sw_rd_i,
  output logic [15:0] sw_rdata_o
);
  cfs_hstate_t state_r, state_nxt;
  logic [15:0] tgt_r, tgt_nxt;
  logic [15:0] cfg_base_r, cfg_base_nxt;
  logic [15:0] reloc_r, reloc_nxt;
  logic [1:0] step_r, step_nxt;
  logic [7:0] last_idx_r, last_idx_nxt;
  logic [7:0] rd_data_r, rd_data_nxt;
  logic noresp_r, noresp_nxt;
  logic refused_r, refused_nxt;
  logic [15:0] io_addr_r, io_addr_nxt;
  logic [7:0] io_wdata_r, io_wdata_nxt;
  logic io_wr_r, io_wr_nxt;
  logic io_rd_r, io_rd_nxt;
  logic [15:0] sw_rdata_nxt;
  logic idle, test_guard;

  // Command sequencer: single cycles, read wait and port relocation
  always_comb begin
    state_nxt = state_r;
    tgt_nxt = tgt_r;
    cfg_base_nxt = cfg_base_r;
    reloc_nxt = reloc_r;
    step_nxt = step_r;
    last_idx_nxt = last_idx_r;
    rd_data_nxt = rd_data_r;
    noresp_nxt = noresp_r;
    refused_nxt = refused_r;
    io_addr_nxt = io_addr_r;
    io_wdata_nxt = io_wdata_r;
    io_wr_nxt = 1'b0;
    io_rd_nxt = 1'b0;
    idle = (state_r == CFS_HS_IDLE);
    test_guard = (last_idx_r == CFS_IDX_TEST_SPLIT);
    for (int k = 0; k < CFS_NUM_TEST; k++) begin
      if (last_idx_r == CFS_TEST_IDX[k]) begin
        test_guard = 1'b1;
      end
    end
    // Writing the status register clears flags; new events win
    if (sw_wr_i && sw_addr_i == CFS_H_STATUS) begin
      noresp_nxt = 1'b0;
      refused_nxt = 1'b0;
    end
    if (sw_wr_i && sw_addr_i == CFS_H_ADDR) begin
      tgt_nxt = sw_wdata_i;
    end
    if (sw_wr_i && sw_addr_i == CFS_H_CFGBASE && idle) begin
      cfg_base_nxt = {sw_wdata_i[15:1], 1'b0};
    end
    case (state_r)
      CFS_HS_IDLE: begin
        if (sw_wr_i && sw_addr_i == CFS_H_WRITE) begin
          if (tgt_r == cfg_base_r + CFS_DATA_PORT_OFS && test_guard) begin
            refused_nxt = 1'b1;
          end else begin
            io_wr_nxt = 1'b1;
            io_addr_nxt = tgt_r;
            io_wdata_nxt = sw_wdata_i[7:0];
            if (tgt_r == cfg_base_r) begin
              last_idx_nxt = sw_wdata_i[7:0];
            end
          end
        end else if (sw_wr_i && sw_addr_i == CFS_H_READ) begin
          io_rd_nxt = 1'b1;
          io_addr_nxt = tgt_r;
          step_nxt = 2'h0;
          state_nxt = CFS_HS_RWAIT;
        end else if (sw_wr_i && sw_addr_i == CFS_H_RELOC) begin
          if (sw_wdata_i[0]) begin
            refused_nxt = 1'b1;
          end else begin
            reloc_nxt = sw_wdata_i;
            step_nxt = 2'h0;
            state_nxt = CFS_HS_RELOC;
          end
        end
      end
      CFS_HS_RWAIT: begin
        // The answer shows one cycle after the strobe is taken, so skip one step
        if (!step_r[0]) begin
          step_nxt = 2'h1;
        end else begin
          rd_data_nxt = link.io_rvalid ? link.io_rdata : CFS_ONES8;
          if (!link.io_rvalid) begin
            noresp_nxt = 1'b1;
          end
          state_nxt = CFS_HS_IDLE;
        end
      end
      CFS_HS_RELOC: begin
        // Index low, data low, index high, data high
        io_wr_nxt = 1'b1;
        io_addr_nxt = step_r[0] ? cfg_base_r + CFS_DATA_PORT_OFS : cfg_base_r;
        if (!step_r[0]) begin
          io_wdata_nxt = step_r[1] ? CFS_IDX_CFG_HI : CFS_IDX_CFG_LO;
          last_idx_nxt = io_wdata_nxt;
        end else begin
          io_wdata_nxt = step_r[1] ? reloc_r[15:8] : reloc_r[7:0];
        end
        step_nxt = step_r + 2'h1;
        if (step_r == CFS_RELOC_LAST) begin
          cfg_base_nxt = reloc_r;
          state_nxt = CFS_HS_IDLE;
        end
      end
      default: begin
        state_nxt = CFS_HS_IDLE;
      end
    endcase
  end

  // Software read port, data in the cycle after the strobe
  always_comb begin
    sw_rdata_nxt = CFS_ZERO16;
    if (sw_rd_i) begin
      if (sw_addr_i == CFS_H_ADDR) begin
        sw_rdata_nxt = tgt_r;
      end else if (sw_addr_i == CFS_H_STATUS) begin
        sw_rdata_nxt[CFS_ST_BUSY] = !idle;
        sw_rdata_nxt[CFS_ST_NORESP] = noresp_r;
        sw_rdata_nxt[CFS_ST_REFUSED] = refused_r;
      end else if (sw_addr_i == CFS_H_RDATA) begin
        sw_rdata_nxt = {CFS_ZERO8, rd_data_r};
      end else if (sw_addr_i == CFS_H_CFGBASE) begin
        sw_rdata_nxt = cfg_base_r;
      end
    end
  end

  // Host registers
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= CFS_HS_IDLE;
      tgt_r <= CFS_ZERO16;
      cfg_base_r <= CFS_CFG_DEF_A;
      reloc_r <= CFS_ZERO16;
      step_r <= 2'h0;
      last_idx_r <= CFS_ZERO8;
      rd_data_r <= CFS_ZERO8;
      noresp_r <= 1'b0;
      refused_r <= 1'b0;
      io_addr_r <= CFS_ZERO16;
      io_wdata_r <= CFS_ZERO8;
      io_wr_r <= 1'b0;
      io_rd_r <= 1'b0;
      sw_rdata_o <= CFS_ZERO16;
    end else begin
      state_r <= state_nxt;
      tgt_r <= tgt_nxt;
      cfg_base_r <= cfg_base_nxt;
      reloc_r <= reloc_nxt;
      step_r <= step_nxt;
      last_idx_r <= last_idx_nxt;
      rd_data_r <= rd_data_nxt;
      noresp_r <= noresp_nxt;
      refused_r <= refused_nxt;
      io_addr_r <= io_addr_nxt;
      io_wdata_r <= io_wdata_nxt;
      io_wr_r <= io_wr_nxt;
      io_rd_r <= io_rd_nxt;
      sw_rdata_o <= sw_rdata_nxt;
    end
  end

  assign link.io_addr = io_addr_r;
  assign link.io_wdata = io_wdata_r;
  assign link.io_wr = io_wr_r;
  assign link.io_rd = io_rd_r;
endmodule

// *** test/cfs_link_props.sv ***
module cfs_link_props
  import cfs_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_rdata,
  input wire logic io_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] idx_r;
  logic [7:0] idx_nxt;
  logic odd_r;
  logic odd_nxt;

  // Last index written at an even port and port parity of the last cycle
  always_comb begin
    idx_nxt = (io_wr && !io_addr[0]) ? io_wdata : idx_r;
    odd_nxt = io_addr[0];
  end

  // Helper registers
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      idx_r <= 8'h00;
      odd_r <= 1'b0;
    end else begin
      idx_r <= idx_nxt;
      odd_r <= odd_nxt;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // Port move: low byte index, even low byte, high byte index, high byte
  sequence s_move_lo;
    io_wr && !io_addr[0] && io_wdata == CFS_IDX_CFG_LO;
  endsequence
  sequence s_move_rest;
    io_wr && io_addr[0] && !io_wdata[0] ##1
      io_wr && !io_addr[0] && io_wdata == CFS_IDX_CFG_HI ##1 io_wr && io_addr[0];
  endsequence

  property p_move_order;
    s_move_lo |=> s_move_rest;
  endproperty
  property p_excl;
    !(io_wr && io_rd);
  endproperty
  property p_rd_single;
    io_rd |=> !io_rd;
  endproperty
  property p_answer_cause;
    io_rvalid |-> $past(io_rd);
  endproperty
  property p_rdata_hold;
    !io_rvalid |-> $stable(io_rdata);
  endproperty
  property p_rsvd28;
    io_rvalid && odd_r && idx_r == CFS_IDX_RSVD28 |-> io_rdata == CFS_ZERO8;
  endproperty
  property p_rsvd_span;
    io_rvalid && odd_r && idx_r inside {[8'h31:8'h5F]} |-> io_rdata == CFS_ZERO8;
  endproperty
  property p_act_upper;
    io_rvalid && odd_r && idx_r == CFS_IDX_ACT |-> io_rdata[7:1] == 7'h00;
  endproperty
  property p_idx_echo;
    io_rvalid && !odd_r |-> io_rdata == idx_r;
  endproperty

  a_move_order: assert property (p_move_order)
    else $error("port move cycles out of order");
  a_excl: assert property (p_excl)
    else $error("read and write together");
  a_rd_single: assert property (p_rd_single)
    else $error("read strobe longer than one cycle");
  a_answer_cause: assert property (p_answer_cause)
    else $error("answer without read");
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without answer");
  a_rsvd28: assert property (p_rsvd28)
    else $error("global reserved byte not zero");
  a_rsvd_span: assert property (p_rsvd_span)
    else $error("reserved bank offset not zero");
  a_act_upper: assert property (p_act_upper)
    else $error("activation upper bits not zero");
  a_idx_echo: assert property (p_idx_echo)
    else $error("index port read wrong");
endmodule

// *** test/tb_config_space_logical_device_regs.sv ***
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin num_errors++; \
  $display("[ERR] %s exp %h got %h", nm, exp, got); end end

module tb_config_space_logical_device_regs;
  import cfs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] sw_addr_i = 4'h0;
  logic [15:0] sw_wdata_i = 16'h0000;
  logic sw_wr_i = 1'b0;
  logic sw_rd_i = 1'b0;
  logic [15:0] sw_rdata_o;
  logic strap_sel_i = 1'b0;
  logic cfg_state_i = 1'b1;
  logic standby_por_i = 1'b0;
  logic pci_reset_i = 1'b0;
  logic soft_reset_i = 1'b0;
  logic test_power_on_clear_i = 1'b0;
  logic [7:0] pwr_set_i = 8'h00;
  logic [7:0] pwr_clr_i = 8'h00;
  logic [7:0] unit_active_o;
  logic [7:0] dev_hit_o;
  logic [15:0] cfg_base_o;
  logic [15:0] port = CFS_CFG_DEF_A;
  logic [7:0] v;
  logic [15:0] s;
  int hit_cnt = 0;
  int num_errors = 0;
  int compares = 0;

  cfs_link_if i_cfs_link_if();
  cfs_cfg_host i_cfs_cfg_host (.core_clk_i(core_clk_i), .rst_i(rst_i), .link(i_cfs_link_if),
    .sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i),
    .sw_rdata_o(sw_rdata_o));
  cfs_cfg_device i_cfs_cfg_device (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .link(i_cfs_link_if), .strap_sel_i(strap_sel_i), .cfg_state_i(cfg_state_i),
    .standby_por_i(standby_por_i), .pci_reset_i(pci_reset_i), .soft_reset_i(soft_reset_i),
    .test_power_on_clear_i(test_power_on_clear_i), .pwr_set_i(pwr_set_i),
    .pwr_clr_i(pwr_clr_i),
    .unit_active_o(unit_active_o), .dev_hit_o(dev_hit_o), .cfg_base_o(cfg_base_o));
  cfs_link_props i_cfs_link_props (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .io_addr(i_cfs_link_if.io_addr), .io_wdata(i_cfs_link_if.io_wdata),
    .io_wr(i_cfs_link_if.io_wr), .io_rd(i_cfs_link_if.io_rd),
    .io_rdata(i_cfs_link_if.io_rdata), .io_rvalid(i_cfs_link_if.io_rvalid));

  // Clock of 20 ns period
  always #10 core_clk_i = ~core_clk_i;

  // Counts decode hits of unit 3
  always @(posedge core_clk_i) begin
    if (dev_hit_o[3] === 1'b1) hit_cnt++;
  end

  task automatic sw_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    sw_addr_i <= a;
    sw_wdata_i <= d;
    sw_wr_i <= 1'b1;
    @(posedge core_clk_i);
    sw_wr_i <= 1'b0;
  endtask

  task automatic sw_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk_i);
    sw_addr_i <= a;
    sw_rd_i <= 1'b1;
    @(posedge core_clk_i);
    sw_rd_i <= 1'b0;
    #1;
    d = sw_rdata_o;
  endtask

  task automatic io_w(input logic [15:0] a, input logic [7:0] d);
    sw_wr(CFS_H_ADDR, a);
    sw_wr(CFS_H_WRITE, {8'h00, d});
  endtask

  task automatic io_r(input logic [15:0] a, output logic [7:0] d);
    logic [15:0] t;
    sw_wr(CFS_H_ADDR, a);
    sw_wr(CFS_H_READ, 16'h0000);
    repeat (3) @(posedge core_clk_i);
    sw_rd(CFS_H_RDATA, t);
    d = t[7:0];
  endtask

  task automatic reg_w(input logic [7:0] i, input logic [7:0] d);
    io_w(port, i);
    io_w(port + CFS_DATA_PORT_OFS, d);
  endtask

  task automatic reg_r(input logic [7:0] i, output logic [7:0] d);
    io_w(port, i);
    io_r(port + CFS_DATA_PORT_OFS, d);
  endtask

  // Pulses {pci, soft, standby} reset for one cycle
  task automatic side_rst(input logic [2:0] m);
    @(posedge core_clk_i);
    {pci_reset_i, soft_reset_i, standby_por_i} <= m;
    @(posedge core_clk_i);
    {pci_reset_i, soft_reset_i, standby_por_i} <= 3'b000;
    repeat (2) @(posedge core_clk_i);
  endtask

  task automatic check_banks(input bit clr);
    for (int d = 0; d < CFS_NUM_LDEV; d++) begin
      reg_w(CFS_IDX_LDN, 8'(d));
      reg_r(CFS_IDX_BASE1_LO, v);
      `CHK("base1_lo", clr ? CFS_ZERO8 : 8'(d * 16), v)
      reg_r(CFS_IDX_BASE2_HI, v);
      `CHK("base2_hi", (!clr && d == 4) ? 8'h03 : CFS_ZERO8, v)
    end
  endtask

  task automatic summarize();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    repeat (40000) @(posedge core_clk_i);
    num_errors++;
    summarize();
  end

  // Main sequence
  initial begin
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    `CHK("cfg_base", CFS_CFG_DEF_A, cfg_base_o)
    for (int k = 0; k < CFS_NUM_TEST; k++) begin
      reg_r(CFS_TEST_IDX[k], v);
      `CHK("test_reg", CFS_ZERO8, v)
    end
    reg_w(CFS_TEST_IDX[0], 8'h5A);
    sw_rd(CFS_H_STATUS, s);
    `CHK("refused", 1'b1, s[CFS_ST_REFUSED])
    sw_wr(CFS_H_STATUS, 16'h0000);
    reg_w(CFS_IDX_RSVD28, CFS_ONES8);
    reg_r(CFS_IDX_RSVD28, v);
    `CHK("rsvd28", CFS_ZERO8, v)
    io_r(port, v);
    `CHK("index_echo", CFS_IDX_RSVD28, v)
    $display("test reset values done");
    for (int d = 0; d < CFS_NUM_LDEV; d++) begin
      reg_w(CFS_IDX_LDN, 8'(d));
      reg_w(CFS_IDX_BASE1_HI, 8'h01);
      reg_w(CFS_IDX_BASE1_LO, 8'(d * 16));
      reg_w(CFS_IDX_BASE2_HI, 8'h03);
    end
    check_banks(1'b0);
    reg_w(CFS_IDX_LDN, 8'h03);
    reg_w(CFS_IDX_ACT, CFS_ONES8);
    reg_r(CFS_IDX_ACT, v);
    `CHK("activate", 8'h01, v)
    `CHK("active", 8'h08, unit_active_o)
    reg_w(8'h31, CFS_ONES8);
    reg_r(8'h31, v);
    `CHK("rsvd31", CFS_ZERO8, v)
    reg_r(8'h5F, v);
    `CHK("rsvd5f", CFS_ZERO8, v)
    $display("test banks done");
    io_w(16'h0133, 8'h00);
    repeat (3) @(posedge core_clk_i);
    `CHK("hit_in", 1, hit_cnt)
    reg_w(CFS_IDX_BASE1_HI, 8'h00);
    io_w(16'h0033, 8'h00);
    repeat (3) @(posedge core_clk_i);
    `CHK("hit_out", 1, hit_cnt)
    pwr_set_i <= 8'h20;
    @(posedge core_clk_i);
    pwr_set_i <= 8'h00;
    repeat (3) @(posedge core_clk_i);
    `CHK("pwr_active", 8'h28, unit_active_o)
    reg_w(CFS_IDX_LDN, 8'h05);
    reg_r(CFS_IDX_ACT, v);
    `CHK("pwr_act_bit", 8'h01, v)
    @(posedge core_clk_i);
    pwr_clr_i <= 8'h20;
    @(posedge core_clk_i);
    pwr_clr_i <= 8'h00;
    repeat (3) @(posedge core_clk_i);
    `CHK("pwr_clear", 8'h08, unit_active_o)
    $display("test decode and power done");
    sw_wr(CFS_H_RELOC, 16'h004A);
    repeat (6) @(posedge core_clk_i);
    `CHK("moved", 16'h004A, cfg_base_o)
    port = 16'h004A;
    reg_r(CFS_IDX_LDN, v);
    `CHK("new_port", 8'h05, v)
    sw_wr(CFS_H_RELOC, 16'h0051);
    repeat (6) @(posedge core_clk_i);
    sw_rd(CFS_H_STATUS, s);
    `CHK("odd_refused", 1'b1, s[CFS_ST_REFUSED])
    `CHK("odd_kept", 16'h004A, cfg_base_o)
    sw_wr(CFS_H_STATUS, 16'h0000);
    $display("test port move done");
    side_rst(3'b010);
    `CHK("soft_port", 16'h004A, cfg_base_o)
    `CHK("soft_active", CFS_ZERO8, unit_active_o)
    check_banks(1'b1);
    // Host view moved aside so its test-index guard lets one split write through
    sw_wr(CFS_H_CFGBASE, 16'h0050);
    io_w(port, CFS_IDX_TEST_SPLIT);
    io_w(port + CFS_DATA_PORT_OFS, CFS_ONES8);
    sw_wr(CFS_H_CFGBASE, port);
    side_rst(3'b001);
    `CHK("stby_port", 16'h004A, cfg_base_o)
    reg_r(CFS_IDX_TEST_SPLIT, v);
    `CHK("split_stby", CFS_SPLIT_TEST_MASK, v)
    @(posedge core_clk_i);
    test_power_on_clear_i <= 1'b1;
    @(posedge core_clk_i);
    test_power_on_clear_i <= 1'b0;
    reg_r(CFS_IDX_TEST_SPLIT, v);
    `CHK("split_tpc", CFS_ZERO8, v)
    side_rst(3'b100);
    `CHK("pci_port", CFS_CFG_DEF_A, cfg_base_o)
    port = CFS_CFG_DEF_A;
    sw_wr(CFS_H_CFGBASE, port);
    cfg_state_i <= 1'b0;
    io_r(port + CFS_DATA_PORT_OFS, v);
    `CHK("no_cfg_rdata", CFS_ONES8, v)
    sw_rd(CFS_H_STATUS, s);
    `CHK("no_cfg_resp", 1'b1, s[CFS_ST_NORESP])
    @(posedge core_clk_i);
    cfg_state_i <= 1'b1;
    strap_sel_i <= 1'b1;
    side_rst(3'b100);
    `CHK("strap_b", CFS_CFG_DEF_B, cfg_base_o)
    $display("test resets done");
    summarize();
  end
endmodule
